// File: lvcs_cfg.svh
// Constants for the LED voltage capture and soft-reset block.
// Assumes a 9-bit register data path addressed by 5-bit register index.
`ifndef LVCS_CFG_SVH
`define LVCS_CFG_SVH
`define LVCS_ADDR_W        5
`define LVCS_DATA_W        9
`define LVCS_ADC_W         8
`define LVCS_OFS_CH1_LATEST 5'h0A
`define LVCS_OFS_CH1_BOFF   5'h0B
`define LVCS_OFS_CH1_BON    5'h0C
`define LVCS_OFS_CH2_LATEST 5'h0D
`define LVCS_OFS_CH2_BOFF   5'h0E
`define LVCS_OFS_CH2_BON    5'h0F
`define LVCS_OFS_SOFT_RST   5'h10
`define LVCS_RESET_KEY      9'h0C3
`define LVCS_DIM_BIT        8
`define LVCS_REG_RESET      9'h000
`define LVCS_ADC_RESET      8'h00
`define LVCS_CH_N           2
`define LVCS_REGS_PER_CH    3
`define LVCS_SLOT_LATEST    5'h00
`define LVCS_SLOT_BOFF      5'h01
`define LVCS_SLOT_BON       5'h02
`endif

// File: lvcs_pkg.sv
// Types shared by the LED voltage capture block.
// Assumes lvcs_cfg.svh is on the include path.
`include "lvcs_cfg.svh"
`default_nettype none
package lvcs_pkg;
	typedef struct packed
	{
		logic                    dim;
		logic [`LVCS_ADC_W-1:0]  latest;
		logic [`LVCS_ADC_W-1:0]  before_off;
		logic [`LVCS_ADC_W-1:0]  before_on;
	} lvcs_chan_t;

	typedef struct packed
	{
		logic                    wr;
		logic                    rd;
		logic [`LVCS_ADDR_W-1:0] addr;
		logic [`LVCS_DATA_W-1:0] wdata;
	} lvcs_req_t;

	typedef enum logic
	{
		LVCS_DIM_LOW,
		LVCS_DIM_HIGH
	} lvcs_dim_t;
endpackage
`default_nettype wire

// File: lvcs_chan.sv
// One channel of LED voltage capture: latest sample, and samples held
// at dimming edges. Assumes dim_i is already synchronised to clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "lvcs_cfg.svh"
module lvcs_chan
	import lvcs_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   dim_i,
	input  wire logic                   conv_start_i,
	input  wire logic                   conv_done_i,
	input  wire logic [`LVCS_ADC_W-1:0] conv_data_i,
	output var  lvcs_chan_t             chan_o
);
	typedef struct packed
	{
		lvcs_chan_t chan;
		logic       dim_prev;
		logic       dim_at_start;
		logic [`LVCS_ADC_W-1:0] last_high;
		logic [`LVCS_ADC_W-1:0] last_low;
	} lvcs_cst_t;

	lvcs_cst_t st_r;
	lvcs_cst_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.dim_prev = dim_i;
		if (conv_start_i)
			st_nxt.dim_at_start = dim_i;
		if (conv_done_i)
		begin
			st_nxt.chan.latest = conv_data_i;
			st_nxt.chan.dim = conv_start_i ? dim_i : st_r.dim_at_start;
			if (dim_i)
				st_nxt.last_high = conv_data_i;
			else
				st_nxt.last_low = conv_data_i;
		end
		if (st_r.dim_prev && !dim_i)
			st_nxt.chan.before_off = st_r.last_high;
		if (!st_r.dim_prev && dim_i)
			st_nxt.chan.before_on = st_r.last_low;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign chan_o = st_r.chan;
endmodule
`default_nettype wire

// File: lvcs_top.sv
// Register access to dual-channel LED voltage captures and soft reset.
// Assumes an external serial front end supplies rd/wr strobes in clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "lvcs_cfg.svh"
module lvcs_top
	import lvcs_pkg::*;
#(
	parameter int unsigned CH_N   = `LVCS_CH_N,
	parameter int unsigned ADC_W  = `LVCS_ADC_W,
	parameter int unsigned DATA_W = `LVCS_DATA_W
)
(
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    dim_input_ch1_i,
	input  wire logic                    dim_input_ch2_i,
	input  wire logic [1:0]              conv_start_i,
	input  wire logic [1:0]              conv_done_i,
	input  wire logic [`LVCS_ADC_W-1:0]  conv_data_i,
	input  wire lvcs_req_t               req_i,
	output logic [`LVCS_DATA_W-1:0]      rdata_o,
	output logic                         rvalid_o,
	output logic                         soft_reset_o
);
	typedef struct packed
	{
		logic [1:0]              sync1;
		logic [1:0]              sync2;
		logic [`LVCS_DATA_W-1:0] rdata;
		logic                    rvalid;
		logic                    soft_rst;
	} lvcs_tst_t;

	lvcs_tst_t  st_r;
	lvcs_tst_t  st_nxt;
	lvcs_chan_t chan [CH_N];
	logic [1:0] dim_pins;

	assign dim_pins = {dim_input_ch2_i, dim_input_ch1_i};

	// Ports and package types fix two channels of 8-bit samples
	generate
		if (CH_N != `LVCS_CH_N)
		begin : g_bad_ch_n
			$error("lvcs_top: CH_N must be 2");
		end

		if (ADC_W != `LVCS_ADC_W)
		begin : g_bad_adc_w
			$error("lvcs_top: ADC_W must be 8");
		end

		if (DATA_W != ADC_W + 1)
		begin : g_bad_data_w
			$error("lvcs_top: DATA_W must be ADC_W plus one");
		end

		if (`LVCS_DIM_BIT != ADC_W)
		begin : g_bad_dim_bit
			$error("lvcs_top: dimming flag must sit above the sample");
		end

		// Capture decode relies on one contiguous window
		if (`LVCS_OFS_CH2_BON - `LVCS_OFS_CH1_LATEST + 1 != CH_N * `LVCS_REGS_PER_CH)
		begin : g_bad_window
			$error("lvcs_top: capture registers must be contiguous");
		end

		// Soft reset must lie outside the capture window
		if (`LVCS_OFS_SOFT_RST <= `LVCS_OFS_CH2_BON)
		begin : g_bad_soft_rst
			$error("lvcs_top: soft reset register overlaps the captures");
		end
	endgenerate

	function automatic logic [`LVCS_DATA_W-1:0] pack_latest(input lvcs_chan_t c);
		pack_latest = {c.dim, c.latest};
	endfunction

	function automatic logic [`LVCS_DATA_W-1:0] pad_adc(input logic [`LVCS_ADC_W-1:0] v);
		pad_adc = {1'h0, v};
	endfunction

	function automatic logic is_capture_addr(input logic [`LVCS_ADDR_W-1:0] a);
		is_capture_addr = (a >= `LVCS_OFS_CH1_LATEST) && (a <= `LVCS_OFS_CH2_BON);
	endfunction

	function automatic logic is_soft_rst_addr(input logic [`LVCS_ADDR_W-1:0] a);
		is_soft_rst_addr = (a == `LVCS_OFS_SOFT_RST);
	endfunction

	function automatic logic is_key_write(input lvcs_req_t r);
		is_key_write = r.wr && is_soft_rst_addr(r.addr) && (r.wdata == `LVCS_RESET_KEY);
	endfunction

	// Slot 0 latest sample, 1 before falling edge, 2 before rising edge
	function automatic logic [`LVCS_DATA_W-1:0] chan_read
	(
		input lvcs_chan_t              c,
		input logic [`LVCS_ADDR_W-1:0] slot
	);
		case (slot)
			`LVCS_SLOT_LATEST: chan_read = pack_latest(c);
			`LVCS_SLOT_BOFF:   chan_read = pad_adc(c.before_off);
			`LVCS_SLOT_BON:    chan_read = pad_adc(c.before_on);
			default:           chan_read = `LVCS_REG_RESET;
		endcase
	endfunction

	function automatic logic [`LVCS_DATA_W-1:0] read_select
	(
		input logic [`LVCS_ADDR_W-1:0] a,
		input lvcs_chan_t              c0,
		input lvcs_chan_t              c1
	);
		read_select = `LVCS_REG_RESET;
		if (is_capture_addr(a))
		begin
			if (a < `LVCS_OFS_CH2_LATEST)
			begin
				read_select = chan_read(c0, a - `LVCS_OFS_CH1_LATEST);
			end
			else
			begin
				read_select = chan_read(c1, a - `LVCS_OFS_CH2_LATEST);
			end
		end
		else if (is_soft_rst_addr(a))
		begin
			read_select = `LVCS_REG_RESET;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < CH_N; g++)
		begin : g_chan
			lvcs_chan u_chan
			(
				.clk_i        (clk_i),
				.sys_rst_i    (sys_rst_i),
				.dim_i        (st_r.sync2[g]),
				.conv_start_i (conv_start_i[g]),
				.conv_done_i  (conv_done_i[g]),
				.conv_data_i  (conv_data_i),
				.chan_o       (chan[g])
			);
		end
	endgenerate

	always_comb
	begin
		st_nxt = st_r;
		// Two flops sit between each dimming pin and the capture logic
		st_nxt.sync1 = dim_pins;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.rvalid = req_i.rd;
		st_nxt.soft_rst = 1'h0;
		if (req_i.rd)
		begin
			st_nxt.rdata = read_select(req_i.addr, chan[0], chan[1]);
		end
		else
		begin
			// Read data holds until the next read
			st_nxt.rdata = st_r.rdata;
		end
		if (req_i.wr)
		begin
			if (is_key_write(req_i))
			begin
				st_nxt.soft_rst = 1'h1;
			end
			else
			begin
				st_nxt.soft_rst = 1'h0;
			end
		end
	end

	// Synchronous reset clears every flop, outputs included
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the registered state
	assign rdata_o      = st_r.rdata;
	assign rvalid_o     = st_r.rvalid;
	assign soft_reset_o = st_r.soft_rst;
endmodule
`default_nettype wire

// File: lvcs_top_checker.sv
// Port assertions for lvcs_top.
// Assumes a bind into lvcs_top, one clock.
`timescale 1ns/1ns
`default_nettype none
module lvcs_top_checker
	import lvcs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire lvcs_req_t  req_i,
	input  wire logic [8:0] rdata_o,
	input  wire logic       rvalid_o,
	input  wire logic       soft_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire logic       rd = req_i.rd;
	wire logic [4:0] a = req_i.addr;
	wire logic       k = req_i.wr && a == 5'h10 && req_i.wdata == 9'h0C3;
	AST_RD: assert property (rd |=> rvalid_o) else $error("no rvalid");
	AST_NRD: assert property (!rd |=> !rvalid_o) else $error("stray rvalid");
	AST_KEY: assert property (k |=> soft_reset_o) else $error("no reset");
	AST_NKEY: assert property (!k |=> !soft_reset_o) else $error("stray reset");
	AST_SR0: assert property (rd && a == 5'h10 |=> rdata_o == 9'h0) else $error("key");
	AST_HOLD: assert property (!rd |=> $stable(rdata_o)) else $error("rdata");
	AST_CAP: assert property (rd && a inside {5'h0B, 5'h0C, 5'h0E, 5'h0F} |=> !rdata_o[8])
		else $error("bit 8");
	AST_UNM: assert property (rd && a > 5'h10 |=> rdata_o == 9'h0) else $error("unmapped");
	cover property (k);
	cover property (rd && a == 5'h0B);
	cover property (rvalid_o && rdata_o[8]);
endmodule
bind lvcs_top lvcs_top_checker u_chk (.clk_i, .sys_rst_i, .req_i, .rdata_o, .rvalid_o,
	.soft_reset_o);
`default_nettype wire

// File: lvcs_adc_model.sv
// ADC and dimming pin model.
// Assumes the bench calls its tasks.
`timescale 1ns/1ns
`default_nettype none
module lvcs_adc_model
(
	input  wire logic       clk_i,
	output var  logic [1:0] st_o,
	output var  logic [1:0] dn_o,
	output var  logic [7:0] cd_o,
	output var  logic [1:0] dim_o
);
	initial {st_o, dn_o, cd_o, dim_o} = 14'h0;
	task automatic conv(int c, logic [7:0] d);
		@(negedge clk_i) st_o[c] = 1'h1;
		@(negedge clk_i) {st_o[c], dn_o[c], cd_o} = {2'h1, d};
		@(negedge clk_i) {dn_o[c], cd_o} = {1'h0, ~d};
	endtask
	task automatic dim(int c, logic v);
		@(negedge clk_i) dim_o[c] = v;
		repeat (8) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: test_lvcs_top.sv
// Bench for lvcs_top.
// Assumes lvcs_adc_model drives the pins.
`timescale 1ns/1ns
`default_nettype none
module test_lvcs_top;
	import lvcs_pkg::*;
	logic       clk_i = 1'h0;
	logic       sys_rst_i = 1'h1;
	logic [1:0] st_o, dn_o, dim_o;
	logic [7:0] cd_o;
	logic [8:0] rdata_o;
	logic       rvalid_o, soft_reset_o;
	lvcs_req_t  req_i = '0;
	int         err_count = 0, checked = 0;
	initial forever #20 clk_i = ~clk_i;
	lvcs_adc_model far (.clk_i, .st_o, .dn_o, .cd_o, .dim_o);
	lvcs_top dut (.clk_i, .sys_rst_i, .dim_input_ch1_i(dim_o[0]), .dim_input_ch2_i(dim_o[1]),
		.conv_start_i(st_o), .conv_done_i(dn_o), .conv_data_i(cd_o), .req_i, .rdata_o,
		.rvalid_o, .soft_reset_o);
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(string n, logic [8:0] e, logic [8:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic rd(logic [4:0] a, logic [8:0] e);
		@(negedge clk_i) req_i = {2'h1, a, 9'h0};
		@(negedge clk_i) req_i.rd = 1'h0;
		chk_bit("rvalid", 1'h1, rvalid_o);
		chk("rdata", e, rvalid_o === 1'h1 ? rdata_o : 9'hX);
		if (rvalid_o !== 1'h1)
			end_of_test();
	endtask
	task automatic wr(logic [4:0] a, logic [8:0] d, logic e);
		@(negedge clk_i) req_i = {2'h2, a, d};
		@(negedge clk_i) req_i.wr = 1'h0;
		chk_bit("srst", e, soft_reset_o);
	endtask
	task automatic t_chan(int c);
		logic [4:0] a;
		a = 5'h0A + 5'(3 * c);
		far.dim(c, 1'h0);
		far.conv(c, 8'h5A);
		rd(a, 9'h05A);
		far.dim(c, 1'h1);
		far.conv(c, 8'hA5);
		rd(a, 9'h1A5);
		far.dim(c, 1'h0);
		rd(a + 5'h1, 9'h0A5);
		far.conv(c, 8'h3C);
		far.dim(c, 1'h1);
		rd(a + 5'h2, 9'h03C);
		wr(a, 9'h1FF, 1'h0);
		rd(a, 9'h03C);
		$display("channel test done");
	endtask
	initial
	begin
		repeat (4) @(negedge clk_i);
		sys_rst_i = 1'h0;
		for (int a = 10; a < 17; a++)
			rd(5'(a), 9'h0);
		$display("reset value test done");
		t_chan(0);
		t_chan(1);
		wr(5'h10, 9'h0C2, 1'h0);
		rd(5'h0A, 9'h03C);
		wr(5'h10, 9'h0C3, 1'h1);
		rd(5'h10, 9'h0);
		rd(5'h11, 9'h0);
		rd(5'h09, 9'h0);
		$display("soft reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
